// ===== rtl/page_relocation_length_check.sv
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "page_reloc_defines.svh"

// Contract
// - Upward page: block above length field is a length fault.
// - A length fault raises abort enable, ending the reference with a trap.
// - Downward page: block below length field is a length fault.
// - Page base is always the page's lowest physical block.
// - Relocation enabled: bus address is base plus virtual address.
// - Top three virtual address bits pick one of eight pairs.
// - Displacement splits into 7-bit block and 6-bit offset.
// - Page base counts 32-word blocks, not bytes.
// - Processor mode picks kernel or user pair set first.
// - Physical block is page base plus virtual block.
// - Offset appended to physical block gives 18-bit address.
// - Each 8K-byte virtual slice maps to its own pair.
// - Descriptor bit 3 gives expansion direction, one meaning downward.
// - Length field is descriptor bits 14 to 8.
// - Enable bit 0 relocates and checks; cleared passes unchanged.
module page_relocation_length_check
  import page_reloc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic xlat_req,
  input wire logic [15:0] virtual_bus_address,
  input wire logic user_mode,
  output logic [17:0] bus_address,
  output logic xlat_done,
  output logic length_fault_n,
  output logic abort_enable,
  output logic relocation_active,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  rd_state_e rd_state_reg;
  rd_state_e rd_state_next;
  logic ctrl_reg;
  logic status_reg;
  logic mask_reg;
  logic [16:0] fault_info_reg;
  logic page_win;
  logic wr_hit;
  logic [15:0] mem_rdata;
  logic [3:0] xl_idx;
  base_t page_base_block;
  logic [15:0] page_descriptor_register;
  logic s1_valid_reg;
  logic [15:0] s1_vaddr_reg;
  logic s1_user_reg;
  logic [3:0] s1_idx_reg;
  block_t virtual_block_number;
  logic [5:0] in_block_offset;
  block_t page_length_field;
  logic expand_direction;
  logic [11:0] phys_block;
  logic over_len;
  logic fault_c;
  logic [31:0] rd_mux;

  assign page_win = avs_address[`PAGE_WIN_BIT];
  assign wr_hit = avs_write && page_win;
  assign relocation_active = ctrl_reg;

  ////////////////////////////////////////////////////////////////////
  // Page register store
  assign xl_idx = {user_mode, virtual_bus_address[`VA_PAGE_HI:`VA_PAGE_LO]};

  page_reg_store page_reg_store_inst (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wr_en(wr_hit),
    .wr_desc(avs_address[`PAGE_DESC_BIT]),
    .wr_idx(avs_address[5:2]),
    .wr_data(avs_writedata[15:0]),
    .wr_be(avs_byteenable[1:0]),
    .xl_idx(xl_idx),
    .xl_base(page_base_block),
    .xl_desc(page_descriptor_register),
    .rd_idx(avs_address[5:2]),
    .rd_desc(avs_address[`PAGE_DESC_BIT]),
    .rd_data(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////
  // Stage one: address held while pair is fetched
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_valid_reg <= 1'b0;
      s1_vaddr_reg <= 16'h0000;
      s1_user_reg <= 1'b0;
      s1_idx_reg <= 4'h0;
    end else begin
      s1_valid_reg <= xlat_req;
      s1_vaddr_reg <= virtual_bus_address;
      s1_user_reg <= user_mode;
      s1_idx_reg <= xl_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Relocation and length check
  assign virtual_block_number =
    s1_vaddr_reg[`VA_BLOCK_HI:`VA_BLOCK_LO];
  assign in_block_offset = s1_vaddr_reg[`VA_OFS_HI:0];
  assign page_length_field =
    page_descriptor_register[`DESC_LEN_HI:`DESC_LEN_LO];
  assign expand_direction = page_descriptor_register[`DESC_DIR_BIT];
  // Base block plus virtual block, base lowest either way
  assign phys_block = page_base_block + {5'h00, virtual_block_number};

  always_comb begin
    if (expand_direction) begin
      over_len = virtual_block_number < page_length_field;
    end else begin
      over_len = virtual_block_number > page_length_field;
    end
  end

  assign fault_c = s1_valid_reg && ctrl_reg && over_len;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_address <= 18'h0_0000;
      xlat_done <= 1'b0;
      length_fault_n <= 1'b1;
      abort_enable <= 1'b0;
    end else begin
      xlat_done <= s1_valid_reg;
      length_fault_n <= !fault_c;
      abort_enable <= fault_c;
      if (s1_valid_reg) begin
        if (ctrl_reg) begin
          bus_address <= {phys_block, in_block_offset};
        end else begin
          bus_address <= {2'b00, s1_vaddr_reg};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control, status, mask
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (avs_write && avs_byteenable[0] &&
                 avs_address == `OFS_CTRL) begin
      ctrl_reg <= avs_writedata[`CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mask_reg <= 1'b0;
    end else if (avs_write && avs_byteenable[0] &&
                 avs_address == `OFS_MASK) begin
      mask_reg <= avs_writedata[`STAT_LEN_FAULT_BIT];
    end
  end

  // Sticky fault, set beats write-one clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_reg <= 1'b0;
    end else if (fault_c) begin
      status_reg <= 1'b1;
    end else if (avs_write && avs_byteenable[0] &&
                 avs_address == `OFS_STATUS &&
                 avs_writedata[`STAT_LEN_FAULT_BIT]) begin
      status_reg <= 1'b0;
    end
  end

  // First faulting address and mode, held while flag set
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fault_info_reg <= 17'h0_0000;
    end else if (fault_c && !status_reg) begin
      fault_info_reg <= {s1_user_reg, s1_vaddr_reg};
    end
  end

  assign irq = status_reg && mask_reg;

  ////////////////////////////////////////////////////////////////////
  // Avalon read sequencing
  always_comb begin
    case (rd_state_reg)
      RD_IDLE: rd_state_next = avs_read ? RD_FETCH : RD_IDLE;
      RD_FETCH: rd_state_next = RD_DONE;
      RD_DONE: rd_state_next = RD_IDLE;
      default: rd_state_next = RD_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_state_reg <= RD_IDLE;
    end else begin
      rd_state_reg <= rd_state_next;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (page_win) begin
      rd_mux = {16'h0000, mem_rdata};
    end else begin
      case (avs_address)
        `OFS_CTRL: rd_mux = {31'h0000_0000, ctrl_reg};
        `OFS_STATUS: rd_mux = {31'h0000_0000, status_reg};
        `OFS_MASK: rd_mux = {31'h0000_0000, mask_reg};
        `OFS_FAULT: rd_mux = {15'h0000, fault_info_reg};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_state_reg == RD_FETCH) begin
      avs_readdata <= rd_mux;
    end
  end

  assign avs_waitrequest = avs_read && (rd_state_reg != RD_DONE);

  ////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_req;
    xlat_req;
  endsequence

  sequence s_answer;
    ##2 xlat_done;
  endsequence

  property p_latency;
    @(posedge mclk) disable iff (sys_rst)
    s_req |-> s_answer;
  endproperty
  a_latency: assert property (p_latency)
    else $error("translation answer not two cycles after request");

  property p_select;
    @(posedge mclk) disable iff (sys_rst)
    xlat_req |=> s1_idx_reg ==
      {$past(user_mode), $past(virtual_bus_address[15:13])};
  endproperty
  a_select: assert property (p_select)
    else $error("wrong page register pair selected");

  property p_up_fault;
    @(posedge mclk) disable iff (sys_rst)
    (s1_valid_reg && ctrl_reg && !expand_direction &&
     virtual_block_number > page_length_field)
    |=> !length_fault_n && abort_enable;
  endproperty
  a_up_fault: assert property (p_up_fault)
    else $error("upward overrun not faulted");

  property p_down_fault;
    @(posedge mclk) disable iff (sys_rst)
    (s1_valid_reg && ctrl_reg && expand_direction)
    |=> length_fault_n ==
      ($past(virtual_block_number) >= $past(page_length_field));
  endproperty
  a_down_fault: assert property (p_down_fault)
    else $error("downward length check wrong");

  property p_abort;
    @(posedge mclk) disable iff (sys_rst)
    !length_fault_n |-> abort_enable && xlat_done ##1 status_reg;
  endproperty
  a_abort: assert property (p_abort)
    else $error("fault without abort or status");

  property p_reloc;
    @(posedge mclk) disable iff (sys_rst)
    (s1_valid_reg && ctrl_reg) |=>
      bus_address[5:0] == $past(s1_vaddr_reg[5:0]) &&
      bus_address[17:6] == 12'($past(page_base_block) +
                               $past(s1_vaddr_reg[12:6]));
  endproperty
  a_reloc: assert property (p_reloc)
    else $error("relocated address wrong");

  property p_pass;
    @(posedge mclk) disable iff (sys_rst)
    (s1_valid_reg && !ctrl_reg) |=>
      bus_address == {2'b00, $past(s1_vaddr_reg)} && length_fault_n;
  endproperty
  a_pass: assert property (p_pass)
    else $error("disabled path not passed through");

  property p_irq;
    @(posedge mclk) disable iff (sys_rst)
    !length_fault_n |-> irq == mask_reg;
  endproperty
  a_irq: assert property (p_irq)
    else $error("fault did not reach interrupt level per mask");

  property p_read_wait;
    @(posedge mclk) disable iff (sys_rst)
    (avs_read && rd_state_reg == RD_IDLE) |->
      avs_waitrequest[*2] ##1 !avs_waitrequest;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read answer not on third cycle");

endmodule // page_relocation_length_check

`default_nettype wire

// ===== include/page_reloc_defines.svh
`ifndef PAGE_RELOC_DEFINES_SVH
`define PAGE_RELOC_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_FAULT 8'h0C
// Page register window: bit 7 set, bit 6 descriptor, bit 5 user
`define PAGE_WIN_BIT 7
`define PAGE_DESC_BIT 6
`define PAGE_USER_BIT 5

// Control and status fields
`define CTRL_ENABLE_BIT 0
`define STAT_LEN_FAULT_BIT 0
`define CTRL_RESET 1'h0

// Virtual address split
`define VA_PAGE_HI 15
`define VA_PAGE_LO 13
`define VA_BLOCK_HI 12
`define VA_BLOCK_LO 6
`define VA_OFS_HI 5

// Descriptor fields
`define DESC_LEN_HI 14
`define DESC_LEN_LO 8
`define DESC_DIR_BIT 3
`define DESC_WMASK 16'h7F08
`define BASE_WMASK 16'h0FFF

`define REG_RESET 16'h0000

`endif

// ===== include/page_reloc_pkg.sv
package page_reloc_pkg;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_FETCH = 2'b01,
    RD_DONE = 2'b10
  } rd_state_e;

  typedef logic [6:0] block_t;
  typedef logic [11:0] base_t;

endpackage

// ===== rtl/page_reg_store.sv
`timescale 1ns/10ps
`default_nettype none
`include "page_reloc_defines.svh"

module page_reg_store (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic wr_desc,
  input wire logic [3:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_be,
  input wire logic [3:0] xl_idx,
  output logic [11:0] xl_base,
  output logic [15:0] xl_desc,
  input wire logic [3:0] rd_idx,
  input wire logic rd_desc,
  output logic [15:0] rd_data
);

  logic [15:0] base_mem [16];
  logic [15:0] desc_mem [16];
  logic [15:0] lane_mask;
  logic [15:0] wmask;

  assign lane_mask = {{8{wr_be[1]}}, {8{wr_be[0]}}};
  assign wmask = lane_mask & (wr_desc ? `DESC_WMASK : `BASE_WMASK);

  ////////////////////////////////////////////////////////////////////
  // Storage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < 16; i++) begin
        base_mem[i] <= `REG_RESET;
        desc_mem[i] <= `REG_RESET;
      end
    end else if (wr_en) begin
      if (wr_desc) begin
        desc_mem[wr_idx] <= (desc_mem[wr_idx] & ~wmask) | (wr_data & wmask);
      end else begin
        base_mem[wr_idx] <= (base_mem[wr_idx] & ~wmask) | (wr_data & wmask);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registered read ports
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      xl_base <= 12'h000;
      xl_desc <= `REG_RESET;
    end else begin
      xl_base <= base_mem[xl_idx][11:0];
      xl_desc <= desc_mem[xl_idx];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_data <= `REG_RESET;
    end else begin
      rd_data <= rd_desc ? desc_mem[rd_idx] : base_mem[rd_idx];
    end
  end

endmodule // page_reg_store

`default_nettype wire

// ===== verif/cpu_side_model.sv
`timescale 1ns/10ps
`default_nettype none

module cpu_side_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic [15:0] go_va,
  input wire logic go_um,
  output logic xlat_req,
  output logic [15:0] virtual_bus_address,
  output logic user_mode
);
  initial begin
    xlat_req = 1'b0;
    virtual_bus_address = 16'h0000;
    user_mode = 1'b0;
  end

  // One-cycle request; lines garbled once released
  always @(posedge mclk) begin
    xlat_req <= go;
    virtual_bus_address <= go ? go_va : ~virtual_bus_address;
    user_mode <= go ? go_um : ~user_mode;
  end
endmodule // cpu_side_model

`default_nettype wire

// ===== verif/page_relocation_length_check_bench.sv
`timescale 1ns/10ps
`default_nettype none

module page_relocation_length_check_bench;
  import page_reloc_pkg::*;
  typedef struct {logic [15:0] va; logic um; logic [17:0] pa; logic f;} row_s;
  logic mclk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, xlat_req, user_mode, xlat_done, length_fault_n;
  logic abort_enable, relocation_active, irq, go = 1'b0, go_um = 1'b0, f, ab;
  logic [15:0] virtual_bus_address, go_va = 16'h0000;
  logic [17:0] bus_address, pa;
  int mismatches = 0, cmp_count = 0, n;
  row_s rows [6] = '{
    '{16'h2a45, 1'b0, 18'h0_4a45, 1'b0}, '{16'h2a80, 1'b0, 18'h0_4a80, 1'b1},
    '{16'hf540, 1'b1, 18'h0_1140, 1'b0}, '{16'hf500, 1'b1, 18'h0_1100, 1'b1},
    '{16'hf540, 1'b0, 18'h0_1540, 1'b1}, '{16'h003f, 1'b0, 18'h0_003f, 1'b0}};

  always #5 mclk = ~mclk;

  page_relocation_length_check page_relocation_length_check_inst (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .xlat_req(xlat_req),
    .virtual_bus_address(virtual_bus_address),
    .user_mode(user_mode),
    .bus_address(bus_address),
    .xlat_done(xlat_done),
    .length_fault_n(length_fault_n),
    .abort_enable(abort_enable),
    .relocation_active(relocation_active),
    .irq(irq)
  );
  cpu_side_model cpu_side_model_inst (.mclk(mclk), .go(go), .go_va(go_va),
    .go_um(go_um), .xlat_req(xlat_req),
    .virtual_bus_address(virtual_bus_address), .user_mode(user_mode));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic br(input logic [7:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic xl(input logic [15:0] va, input logic um);
    go <= 1'b1;
    go_va <= va;
    go_um <= um;
    @(posedge mclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (xlat_done !== 1'b1);
    pa = bus_address;
    f = ~length_fault_n;
    ab = abort_enable;
    chk("latency", 32'(n), 32'd3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk("reloc_rst", {31'd0, relocation_active}, 32'd0);
    chk("flt_rst", {31'd0, length_fault_n}, 32'd1);
    $display("reset test done");
    br(8'h10, rd);
    chk("unmapped", rd, 32'h0000_0000);
    bw(8'hf8, 32'h0000_ffff);
    br(8'hf8, rd);
    chk("desc_mask", rd, 32'h0000_7f08);
    $display("register test done");
    bw(8'h84, 32'h0000_0100);
    bw(8'hc4, 32'h0000_2900);
    bw(8'hbc, 32'h0000_0ff0);
    bw(8'hfc, 32'h0000_5508);
    bw(8'h00, 32'h0000_0001);
    @(posedge mclk);
    chk("reloc_on", {31'd0, relocation_active}, 32'd1);
    foreach (rows[i]) begin
      xl(rows[i].va, rows[i].um);
      chk("addr", {14'd0, pa}, {14'd0, rows[i].pa});
      chk("fault", {31'd0, f}, {31'd0, rows[i].f});
      chk("abort", {31'd0, ab}, {31'd0, rows[i].f});
      $display("row %0d done", i);
    end
    br(8'h04, rd);
    chk("status", rd, 32'h0000_0001);
    br(8'h0c, rd);
    chk("fault_info", rd, 32'h0000_2a80);
    chk("irq_masked", {31'd0, irq}, 32'd0);
    bw(8'h08, 32'h0000_0001);
    @(posedge mclk);
    chk("irq_on", {31'd0, irq}, 32'd1);
    bw(8'h04, 32'h0000_0001);
    @(posedge mclk);
    chk("irq_off", {31'd0, irq}, 32'd0);
    br(8'h04, rd);
    chk("status_clr", rd, 32'h0000_0000);
    xl(16'h2a80, 1'b0);
    chk("irq_fault", {31'd0, irq}, 32'd1);
    $display("interrupt test done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk("reloc_rst2", {31'd0, relocation_active}, 32'd0);
    chk("irq_rst2", {31'd0, irq}, 32'd0);
    br(8'hf8, rd);
    chk("desc_rst2", rd, 32'h0000_0000);
    $display("mid-run reset test done");
    bw(8'h00, 32'h0000_0000);
    xl(16'hf500, 1'b1);
    chk("pass_addr", {14'd0, pa}, 32'h0000_f500);
    chk("pass_fault", {31'd0, f}, 32'd0);
    $display("disable test done");
    summarize();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    summarize();
  end
endmodule // page_relocation_length_check_bench

`default_nettype wire
